//--- hdl/usc_params.svh
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH

// Register addresses on the byte-wide register port
`define USC_ADDR_TX_HOLD   8'hB8
`define USC_ADDR_RX_HOLD   8'hB9
`define USC_ADDR_CTRL_STAT 8'hBA
`define USC_ADDR_RX_STAT   8'hBB
`define USC_ADDR_IRQ_CLK   8'hBC
`define USC_ADDR_BAUD_DIV  8'hBD

// Reset values
`define USC_RST_BYTE       8'h00
`define USC_RST_CTRL       5'h00
`define USC_RST_TX_EMPTY   1'b1

// Only software writable bit of the receive status register
`define USC_BIT_ADDRESS_WAIT_MODE       3'h2

// Oversampling: last tick of a bit, start check point, vote window
`define USC_OS_LAST_ASYNC  4'hF
`define USC_OS_LAST_SYNC   4'h0
`define USC_OS_HALF        4'h8
`define USC_VOTE_FIRST     4'h7
`define USC_VOTE_LAST      4'h9

// Data bit counts
`define USC_BITS_SEVEN     4'h7
`define USC_BITS_EIGHT     4'h8
`define USC_BITS_NINE      4'h9

// Parity selection codes {parity_sel_hi, ninth_or_parity_lo}
`define USC_PAR_ODD        2'h0
`define USC_PAR_EVEN       2'h1
`define USC_PAR_MARK       2'h2
`define USC_PAR_SPACE      2'h3

`endif

//--- hdl/usc_pkg.sv
package usc_pkg;

    // Writable part of the control and status register
    typedef struct packed {
        logic parity_enable;
        logic parity_sel_hi;
        logic ninth_or_parity_lo;
        logic frame_length_sel_hi;
        logic frame_length_sel_lo;
    } usc_ctrl_t;

    // Receive status register image, bit 7 first
    typedef struct packed {
        logic overrun_fault;
        logic framing_fault;
        logic parity_fault;
        logic line_break_seen;
        logic received_ninth_bit;
        logic address_wait_mode;
        logic transmit_active;
        logic receive_fault_hold;
    } usc_rx_stat_t;

    // Interrupt and clock select register, bit 7 first
    typedef struct packed {
        logic two_stop_select;
        logic force_line_low;
        logic tx_pin_enable;
        logic sync_mode_select;
        logic rx_clock_external;
        logic tx_clock_external;
        logic rx_irq_enable;
        logic tx_irq_enable;
    } usc_irq_clk_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_BITS,
        RX_STOP
    } usc_rx_state_t;

endpackage : usc_pkg

//--- hdl/usc_top.sv
// How it works
// - Global fault is OR of four faults
// - Received character sets full, read clears
// - Empty sets on shifter load, write clears
// - Overrun flag bit 7, clear on read
// - Framing fault held until status read
// - Parity fault held until status read
// - Line break flag held until status read
// - Ninth received bit stored, read only
// - Attention mode cleared by ninth bit one
// - Transmit active until last stop ends
// - Fault hold set on framing or break, line high clears
// - Stop select picks one or two stops
// - Force low holds serial output low
// - Pin enable routes transmitter onto pin
// - Mode select picks async or sync
// - Receiver clock internal or shift pin
// - Transmitter clock internal or shift pin
// - Receive enable gates receiver interrupt
// - Transmit enable gates transmitter interrupt
// - Seven, eight, nine bits or loopback
// - Parity extra to data, hardware made
// - Frame length code decode
// - Transmit interrupt while empty and enabled
// - Receive interrupt while full and enabled
// - Async sixteen ticks per bit, sync one
//
// Our own choice: strobed register access.
`include "usc_params.svh"

module usc_top #(
    parameter int DIV_W = 8
) (
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       SERIAL_IN_I,
    input  wire logic       PORT_GP_I,
    output logic            PORT_PIN_O,
    input  wire logic       SHIFT_CLK_I,
    output logic            SHIFT_CLK_O,
    output logic            SHIFT_CLK_OE_N_O,
    output logic            IRQ_RX_O,
    output logic            IRQ_TX_O
);

    // Divisor register is DIV_W bits, at most one byte wide
    if (DIV_W < 1 || DIV_W > 8) begin : g_chk
        $error("DIV_W must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////
    // Helper functions

    // Data bits plus parity bit of the current frame
    function automatic logic [3:0] frame_m(input usc_pkg::usc_ctrl_t c);
        logic [3:0] n;
        n = c.frame_length_sel_hi ? `USC_BITS_NINE :
            (c.frame_length_sel_lo ? `USC_BITS_SEVEN : `USC_BITS_EIGHT);
        return n + {3'h0, c.parity_enable & ~c.frame_length_sel_hi};
    endfunction : frame_m

    // Parity over seven or eight data bits
    function automatic logic par_bit(input logic [7:0] d, input logic seven,
                                     input logic [1:0] sel);
        logic x;
        x = seven ? ^d[6:0] : ^d;
        case (sel)
            `USC_PAR_ODD:  par_bit = ~x;
            `USC_PAR_EVEN: par_bit = x;
            `USC_PAR_MARK: par_bit = 1'b1;
            default:       par_bit = 1'b0;
        endcase
    endfunction : par_bit

    // Two of three majority
    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    ////////////////////////////////////////////////////////////////////
    // Declarations

    usc_pkg::usc_ctrl_t    ctrl_reg;
    usc_pkg::usc_irq_clk_t ic_reg;
    usc_pkg::usc_rx_state_t rx_st_reg;
    logic [DIV_W-1:0] div_reg, div_cnt_reg;
    logic [7:0]  tx_hold_reg, rx_hold_reg, rdata_reg;
    logic [11:0] tx_sh_reg;
    logic [3:0]  tx_left_reg, tx_os_reg, rx_os_reg, rx_idx_reg;
    logic [8:0]  rx_sh_reg;
    logic [2:0]  votes_reg, rxd_sync_reg, sck_sync_reg;
    logic        rxd_reg, sck_reg, tick_out_reg;
    logic        tx_empty_reg, rx_full_reg, err_reg;
    logic        ovr_reg, frm_reg, par_reg, lbrk_reg;
    logic        nine_reg, address_wait_mode_reg, transmit_active_reg, receive_fault_hold_reg;
    logic        pin_reg, irq_rx_reg, irq_tx_reg, sck_oe_n_reg;

    ////////////////////////////////////////////////////////////////////
    // Register port decode

    wire wr_txh = WR_I && (ADDR_I == `USC_ADDR_TX_HOLD);
    wire wr_ctl = WR_I && (ADDR_I == `USC_ADDR_CTRL_STAT);
    wire wr_rxs = WR_I && (ADDR_I == `USC_ADDR_RX_STAT);
    wire wr_ic  = WR_I && (ADDR_I == `USC_ADDR_IRQ_CLK);
    wire wr_div = WR_I && (ADDR_I == `USC_ADDR_BAUD_DIV);
    wire rd_rxh = RD_I && (ADDR_I == `USC_ADDR_RX_HOLD);
    wire rd_rxs = RD_I && (ADDR_I == `USC_ADDR_RX_STAT);

    // Status images assembled from live flags
    usc_pkg::usc_rx_stat_t rxs_img;
    assign rxs_img = '{ovr_reg, frm_reg, par_reg, lbrk_reg,
                       nine_reg, address_wait_mode_reg, transmit_active_reg, receive_fault_hold_reg};
    wire [7:0] ctl_img = {ctrl_reg, err_reg, rx_full_reg, tx_empty_reg};

    // Unmapped addresses read as zero
    logic [7:0] rd_mux;
    always_comb begin
        if (ADDR_I == `USC_ADDR_TX_HOLD)
            rd_mux = tx_hold_reg;
        else if (ADDR_I == `USC_ADDR_RX_HOLD)
            rd_mux = rx_hold_reg;
        else if (ADDR_I == `USC_ADDR_CTRL_STAT)
            rd_mux = ctl_img;
        else if (ADDR_I == `USC_ADDR_RX_STAT)
            rd_mux = rxs_img;
        else if (ADDR_I == `USC_ADDR_IRQ_CLK)
            rd_mux = ic_reg;
        else if (ADDR_I == `USC_ADDR_BAUD_DIV)
            rd_mux = 8'(div_reg);
        else
            rd_mux = `USC_RST_BYTE;
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change accepted when 2 and 3 agree

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            rxd_sync_reg <= 3'h7;
            sck_sync_reg <= 3'h0;
            rxd_reg      <= 1'b1;
            sck_reg      <= 1'b0;
        end else begin
            rxd_sync_reg <= {rxd_sync_reg[1:0], SERIAL_IN_I};
            sck_sync_reg <= {sck_sync_reg[1:0], SHIFT_CLK_I};
            if (rxd_sync_reg[1] == rxd_sync_reg[2])
                rxd_reg <= rxd_sync_reg[2];
            if (sck_sync_reg[1] == sck_sync_reg[2])
                sck_reg <= sck_sync_reg[2];
        end
    end

    wire ext_rise = sck_sync_reg[1] & sck_sync_reg[2] & ~sck_reg;
    wire ext_fall = ~sck_sync_reg[1] & ~sck_sync_reg[2] & sck_reg;

    ////////////////////////////////////////////////////////////////////
    // Baud divider; divisor zero stops the internal clock

    wire int_tick = (div_reg != '0) && (div_cnt_reg == '0);

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            div_cnt_reg  <= '0;
            tick_out_reg <= 1'b0;
        end else begin
            if (div_cnt_reg == '0)
                div_cnt_reg <= div_reg - 1'b1;
            else
                div_cnt_reg <= div_cnt_reg - 1'b1;
            if (int_tick)
                tick_out_reg <= ~tick_out_reg;
        end
    end

    // Sync mode: shift out on rising, sample on falling clock edge
    // mode and rate
    wire ssel     = ic_reg.sync_mode_select;
    wire int_rise = int_tick & (~ssel | ~tick_out_reg);
    wire int_fall = int_tick & (~ssel | tick_out_reg);
    wire [3:0] os_last = ssel ? `USC_OS_LAST_SYNC : `USC_OS_LAST_ASYNC;
    wire tx_tick = ic_reg.tx_clock_external ? ext_rise : int_rise;
    wire rx_tick = ic_reg.rx_clock_external ?
                   (ssel ? ext_fall : ext_rise) : int_fall;

    ////////////////////////////////////////////////////////////////////
    // Frame format decode

    wire        nine   = ctrl_reg.frame_length_sel_hi;
    wire        seven  = ctrl_reg.frame_length_sel_lo & ~nine;
    wire        loop   = nine & ctrl_reg.frame_length_sel_lo;
    wire        par_on = ctrl_reg.parity_enable & ~nine;
    wire [1:0]  psel   = {ctrl_reg.parity_sel_hi, ctrl_reg.ninth_or_parity_lo};
    wire [3:0]  m      = frame_m(ctrl_reg);
    wire [3:0]  stops  = ic_reg.two_stop_select ? 4'h2 : 4'h1;
    wire [3:0]  tx_tot = 4'h1 + m + stops;

    // payload LSB first, unused upper bits idle high
    wire        tx_p = par_bit(tx_hold_reg, seven, psel);
    logic [8:0] tx_pay;
    always_comb begin
        if (nine)
            tx_pay = {ctrl_reg.ninth_or_parity_lo, tx_hold_reg};
        else if (seven)
            tx_pay = {1'b1, par_on ? tx_p : 1'b1, tx_hold_reg[6:0]};
        else
            tx_pay = {par_on ? tx_p : 1'b1, tx_hold_reg};
    end

    ////////////////////////////////////////////////////////////////////
    // Transmitter

    wire tx_bit_end = transmit_active_reg && tx_tick && (tx_os_reg == os_last);
    wire tx_last    = tx_bit_end && (tx_left_reg == 4'h1);
    // Never load in a transmit hold write cycle, so a new byte is not overtaken
    wire tx_load    = !tx_empty_reg && !wr_txh && (!transmit_active_reg || tx_last);

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            tx_sh_reg    <= '1;
            tx_left_reg  <= 4'h0;
            tx_os_reg    <= 4'h0;
            transmit_active_reg     <= 1'b0;
            tx_empty_reg <= `USC_RST_TX_EMPTY;
        end else begin
            if (tx_load) begin
                tx_sh_reg    <= {2'b11, tx_pay, 1'b0};
                tx_left_reg  <= tx_tot;
                tx_os_reg    <= 4'h0;
                transmit_active_reg     <= 1'b1;
                tx_empty_reg <= 1'b1;
            end else begin
                if (wr_txh)
                    tx_empty_reg <= 1'b0;
                if (tx_last)
                    transmit_active_reg <= 1'b0;
                if (transmit_active_reg && tx_tick)
                    tx_os_reg <= (tx_os_reg == os_last) ? 4'h0 : tx_os_reg + 4'h1;
                if (tx_bit_end) begin
                    tx_sh_reg   <= {1'b1, tx_sh_reg[11:1]};
                    tx_left_reg <= tx_left_reg - 4'h1;
                end
            end
        end
    end

    wire tx_line = ic_reg.force_line_low ? 1'b0 : (!transmit_active_reg || tx_sh_reg[0]);

    ////////////////////////////////////////////////////////////////////
    // Receiver

    // loopback feeds transmitter line to receiver
    wire rx_in     = loop ? tx_line : rxd_reg;
    wire rx_bitend = rx_tick && (rx_os_reg == os_last);
    wire rx_bit    = ssel ? rx_in : maj3(votes_reg);
    wire rx_done   = (rx_st_reg == usc_pkg::RX_STOP) && rx_bitend;
    wire [8:0] msk = 9'h1FF >> (4'h9 - m);
    wire rx_zero   = (rx_sh_reg & msk) == 9'h000;
    wire rx_pbit   = seven ? rx_sh_reg[7] : rx_sh_reg[8];
    wire rx_ninth  = rx_sh_reg[8];
    // Break: whole frame low including stop
    wire set_brk   = rx_done && !rx_bit && rx_zero;
    wire set_frm   = rx_done && !rx_bit && !rx_zero;
    wire set_par   = rx_done && par_on &&
                     (rx_pbit != par_bit(rx_sh_reg[7:0], seven, psel));
    // attention mode discards characters without ninth bit
    wire rx_take   = rx_done && (!address_wait_mode_reg || (nine && rx_ninth));
    wire set_ovr   = rx_take && rx_full_reg;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            rx_st_reg  <= usc_pkg::RX_IDLE;
            rx_os_reg  <= 4'h0;
            rx_idx_reg <= 4'h0;
            rx_sh_reg  <= 9'h000;
            votes_reg  <= 3'h0;
        end else if (rx_tick) begin
            rx_os_reg <= (rx_os_reg == os_last) ? 4'h0 : rx_os_reg + 4'h1;
            if (rx_os_reg >= `USC_VOTE_FIRST && rx_os_reg <= `USC_VOTE_LAST)
                votes_reg <= {votes_reg[1:0], rx_in};
            case (rx_st_reg)
                usc_pkg::RX_IDLE: begin
                    rx_os_reg  <= ssel ? 4'h0 : 4'h1;
                    rx_idx_reg <= 4'h0;
                    // A held fault waits for the line to go high first
                    if (!rx_in && !receive_fault_hold_reg)
                        rx_st_reg <= ssel ? usc_pkg::RX_BITS : usc_pkg::RX_START;
                end
                usc_pkg::RX_START: begin
                    if (rx_os_reg == `USC_OS_HALF && rx_in)
                        rx_st_reg <= usc_pkg::RX_IDLE;
                    else if (rx_bitend)
                        rx_st_reg <= usc_pkg::RX_BITS;
                end
                usc_pkg::RX_BITS: begin
                    if (rx_bitend) begin
                        rx_sh_reg[rx_idx_reg] <= rx_bit;
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == m - 4'h1)
                            rx_st_reg <= usc_pkg::RX_STOP;
                    end
                end
                default: begin
                    if (rx_bitend)
                        rx_st_reg <= usc_pkg::RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags; a set in the same cycle as its clear wins, except for attention mode

    wire ovr_next  = set_ovr | (ovr_reg & ~rd_rxs);
    wire frm_next  = set_frm | (frm_reg & ~rd_rxs);
    wire par_next  = set_par | (par_reg & ~rd_rxs);
    wire lbrk_next = set_brk | (lbrk_reg & ~rd_rxs);

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ovr_reg     <= 1'b0;
            frm_reg     <= 1'b0;
            par_reg     <= 1'b0;
            lbrk_reg    <= 1'b0;
            err_reg     <= 1'b0;
            rx_full_reg <= 1'b0;
            receive_fault_hold_reg    <= 1'b0;
            nine_reg    <= 1'b0;
            address_wait_mode_reg    <= 1'b0;
            rx_hold_reg <= `USC_RST_BYTE;
        end else begin
            ovr_reg  <= ovr_next;
            frm_reg  <= frm_next;
            par_reg  <= par_next;
            lbrk_reg <= lbrk_next;
            err_reg  <= ovr_next | frm_next | par_next | lbrk_next;
            rx_full_reg <= rx_take | (rx_full_reg & ~rd_rxh);
            receive_fault_hold_reg <= set_frm | set_brk | (receive_fault_hold_reg & ~rxd_reg);
            if (rx_take) begin
                rx_hold_reg <= seven ? {1'b0, rx_sh_reg[6:0]} : rx_sh_reg[7:0];
                nine_reg    <= nine & rx_ninth;
            end
            // attention clear wins over a write
            if (rx_done && address_wait_mode_reg && nine && rx_ninth)
                address_wait_mode_reg <= 1'b0;
            else if (wr_rxs)
                address_wait_mode_reg <= WDATA_I[`USC_BIT_ADDRESS_WAIT_MODE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ctrl_reg    <= `USC_RST_CTRL;
            ic_reg      <= `USC_RST_BYTE;
            div_reg     <= '0;
            tx_hold_reg <= `USC_RST_BYTE;
        end else begin
            if (wr_txh)
                tx_hold_reg <= WDATA_I;
            if (wr_ctl)
                ctrl_reg <= WDATA_I[7:3];
            if (wr_ic)
                ic_reg <= WDATA_I;
            if (wr_div)
                div_reg <= WDATA_I[DIV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            rdata_reg    <= `USC_RST_BYTE;
            pin_reg      <= 1'b1;
            irq_rx_reg   <= 1'b0;
            irq_tx_reg   <= 1'b0;
            sck_oe_n_reg <= 1'b1;
        end else begin
            rdata_reg <= RD_I ? rd_mux : `USC_RST_BYTE;
            pin_reg <= ic_reg.tx_pin_enable ? tx_line : PORT_GP_I;
            irq_rx_reg <= rx_full_reg & ic_reg.rx_irq_enable;
            irq_tx_reg <= tx_empty_reg & ic_reg.tx_irq_enable;
            // Drive the clock pin only when no section takes it as input
            sck_oe_n_reg <= ic_reg.rx_clock_external | ic_reg.tx_clock_external;
        end
    end

    assign RDATA_O          = rdata_reg;
    assign PORT_PIN_O       = pin_reg;
    assign SHIFT_CLK_O      = tick_out_reg;
    assign SHIFT_CLK_OE_N_O = sck_oe_n_reg;
    assign IRQ_RX_O         = irq_rx_reg;
    assign IRQ_TX_O         = irq_tx_reg;

endmodule : usc_top

//--- test/usc_top_sva.sv
`include "usc_params.svh"

module usc_top_sva #(
    parameter int DIV_W = 8
) (
    input wire logic       CLK_I,
    input wire logic       RSTN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       SERIAL_IN_I,
    input wire logic       PORT_GP_I,
    input wire logic       PORT_PIN_O,
    input wire logic       SHIFT_CLK_I,
    input wire logic       SHIFT_CLK_O,
    input wire logic       SHIFT_CLK_OE_N_O,
    input wire logic       IRQ_RX_O,
    input wire logic       IRQ_TX_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    // Shadow of the select register, ports alone cannot show it
    logic [7:0]            sel_reg;
    usc_pkg::usc_irq_clk_t sel;
    wire                   sel_wr = WR_I && ADDR_I == `USC_ADDR_IRQ_CLK;
    assign sel = sel_reg;
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            sel_reg <= 8'h00;
        end else if (sel_wr) begin
            sel_reg <= WDATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////
    property p_rdata_idle;
        !$past(RD_I) |-> RDATA_O == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
    property p_unmapped;
        RD_I && (ADDR_I < `USC_ADDR_TX_HOLD || ADDR_I > `USC_ADDR_BAUD_DIV) |=> RDATA_O == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_readback;
        RD_I && ADDR_I == `USC_ADDR_IRQ_CLK |=> RDATA_O == $past(sel_reg);
    endproperty
    a_readback: assert property (p_readback)
        else $error("select register readback wrong");
    property p_irq_tx;
        (!sel.tx_irq_enable)[*2] |-> !IRQ_TX_O;
    endproperty
    a_irq_tx: assert property (p_irq_tx)
        else $error("transmit irq while disabled");
    property p_irq_rx;
        (!sel.rx_irq_enable)[*2] |-> !IRQ_RX_O;
    endproperty
    a_irq_rx: assert property (p_irq_rx)
        else $error("receive irq while disabled");
    property p_clk_oe;
        sel_wr |=> ##1 SHIFT_CLK_OE_N_O == ($past(sel_reg[3]) | $past(sel_reg[2]));
    endproperty
    a_clk_oe: assert property (p_clk_oe)
        else $error("shift clock enable wrong");
    property p_brk;
        (sel.force_line_low && sel.tx_pin_enable)[*4] |-> !PORT_PIN_O;
    endproperty
    a_brk: assert property (p_brk)
        else $error("pin not held low in break");
    property p_gp;
        (!sel.tx_pin_enable)[*3] |-> PORT_PIN_O == $past(PORT_GP_I);
    endproperty
    a_gp: assert property (p_gp)
        else $error("pin does not follow general value");
endmodule : usc_top_sva

bind usc_top usc_top_sva #(.DIV_W(DIV_W)) u_sva (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SERIAL_IN_I(SERIAL_IN_I),
    .PORT_GP_I(PORT_GP_I), .PORT_PIN_O(PORT_PIN_O), .SHIFT_CLK_I(SHIFT_CLK_I), .SHIFT_CLK_O(SHIFT_CLK_O),
    .SHIFT_CLK_OE_N_O(SHIFT_CLK_OE_N_O), .IRQ_RX_O(IRQ_RX_O), .IRQ_TX_O(IRQ_TX_O));

//--- test/usc_far_end.sv
module usc_far_end (
    input  wire logic clk_i,
    input  wire logic pin_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Divisor 1 gives sixteen system cycles per bit
    localparam int BIT_CYC = 16;

    // Line idles high between frames
    initial line_o = 1'b1;

    ////////////////////////////////////////////////////////////////
    task automatic put(input logic b);
        line_o <= b;
        repeat (BIT_CYC) @(posedge clk_i);
    endtask : put
    task automatic send(input logic [9:0] d, input int n, input logic stp);
        @(posedge clk_i);
        put(1'b0);
        for (int i = 0; i < n; i++) begin
            put(d[i]);
        end
        put(stp);
        line_o <= 1'b1;
    endtask : send
    task automatic recv(output logic [8:0] d, input int n);
        d = '0;
        @(posedge clk_i);
        while (pin_i) @(posedge clk_i);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CYC) @(posedge clk_i);
            d[i] = pin_i;
        end
    endtask : recv
endmodule : usc_far_end

//--- test/test_usart_status_control.sv
`include "usc_params.svh"

module test_usart_status_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk, rst_n, wr_s, rd_s, gp, line, pin, irq_rx, irq_tx;
    logic [7:0] addr, wdata, rdata;
    int         fails, checks_done;

    usc_top #(.DIV_W(8)) dut (.CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .SERIAL_IN_I(line), .PORT_GP_I(gp), .PORT_PIN_O(pin),
        .SHIFT_CLK_I(1'b1), .SHIFT_CLK_O(), .SHIFT_CLK_OE_N_O(), .IRQ_RX_O(irq_rx), .IRQ_TX_O(irq_tx));
    usc_far_end far (.clk_i(clk), .pin_i(pin), .line_o(line));

    // Clock and a toggling general-purpose pin value
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) gp <= ~gp;

    ////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Read one register and compare the masked bits
    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask : rchk
    task automatic t_reset();
        rchk(`USC_ADDR_CTRL_STAT, 8'hFF, 8'h01);
        rchk(`USC_ADDR_RX_STAT, 8'hFF, 8'h00);
        rchk(`USC_ADDR_IRQ_CLK, 8'hFF, 8'h00);
        rchk(8'h00, 8'hFF, 8'h00);
        wr(8'h00, 8'hFF);
        wr(`USC_ADDR_IRQ_CLK, 8'h0C);
        wr(`USC_ADDR_IRQ_CLK, 8'h01);
        step(2);
        chk({7'h0, irq_tx}, 8'h01);
        wr(`USC_ADDR_BAUD_DIV, 8'h01);
        // Divider counter first runs down from the top before ticking
        step(260);
        wr(`USC_ADDR_IRQ_CLK, 8'h02);
    endtask : t_reset
    // Seven, eight and nine bit frames of one pattern
    task automatic t_formats();
        logic [7:0] code [3] = '{8'h08, 8'h00, 8'h10};
        for (int k = 0; k < 3; k++) begin
            wr(`USC_ADDR_CTRL_STAT, code[k]);
            far.send(10'h1A5, 7 + k, 1'b1);
            step(24);
            chk({7'h0, irq_rx}, 8'h01);
            rchk(`USC_ADDR_RX_STAT, 8'h08, (k == 2) ? 8'h08 : 8'h00);
            rchk(`USC_ADDR_RX_HOLD, 8'hFF, (k == 0) ? 8'h25 : 8'hA5);
            step(2);
            chk({7'h0, irq_rx}, 8'h00);
        end
    endtask : t_formats
    // Framing, break, overrun, parity; flags clear on status read
    task automatic t_faults();
        logic [9:0] fd [4] = '{10'h00F, 10'h000, 10'h0A5, 10'h001};
        logic [7:0] fc [4] = '{8'h00, 8'h00, 8'h00, 8'hA0};
        logic [7:0] fm [4] = '{8'hF0, 8'h10, 8'h80, 8'hF0};
        logic [7:0] fe [4] = '{8'h40, 8'h10, 8'h80, 8'h20};
        logic [7:0] fh [4] = '{8'h0F, 8'h00, 8'hA5, 8'h01};
        for (int i = 0; i < 4; i++) begin
            wr(`USC_ADDR_CTRL_STAT, fc[i]);
            far.send(fd[i], (i == 3) ? 9 : 8, i > 1);
            if (i == 2) far.send(fd[i], 8, 1'b1);
            step(24);
            rchk(`USC_ADDR_CTRL_STAT, 8'h04, 8'h04);
            rchk(`USC_ADDR_RX_STAT, fm[i], fe[i]);
            rchk(`USC_ADDR_RX_STAT, 8'hF0, 8'h00);
            rchk(`USC_ADDR_RX_HOLD, 8'hFF, fh[i]);
        end
    endtask : t_faults
    task automatic t_address_wait_mode();
        wr(`USC_ADDR_CTRL_STAT, 8'h10);
        wr(`USC_ADDR_RX_STAT, 8'h04);
        far.send(10'h033, 9, 1'b1);
        step(24);
        rchk(`USC_ADDR_CTRL_STAT, 8'h02, 8'h00);
        far.send(10'h144, 9, 1'b1);
        step(24);
        rchk(`USC_ADDR_RX_STAT, 8'h0C, 8'h08);
        rchk(`USC_ADDR_RX_HOLD, 8'hFF, 8'h44);
    endtask : t_address_wait_mode
    task automatic t_tx();
        logic [8:0] d;
        wr(`USC_ADDR_CTRL_STAT, 8'h00);
        wr(`USC_ADDR_IRQ_CLK, 8'h20);
        // Let the pin settle on the idle line before hunting for a start
        step(2);
        fork
            far.recv(d, 8);
            begin
                wr(`USC_ADDR_TX_HOLD, 8'h55);
                step(3);
                rchk(`USC_ADDR_RX_STAT, 8'h02, 8'h02);
                rchk(`USC_ADDR_CTRL_STAT, 8'h01, 8'h01);
            end
        join
        step(40);
        rchk(`USC_ADDR_RX_STAT, 8'h02, 8'h00);
        chk(d[7:0], 8'h55);
        wr(`USC_ADDR_IRQ_CLK, 8'h60);
        step(6);
        chk({7'h0, pin}, 8'h00);
        wr(`USC_ADDR_IRQ_CLK, 8'h00);
    endtask : t_tx
    // Loopback of a nine bit frame; two stops keep transmit active longer
    task automatic t_loop();
        wr(`USC_ADDR_CTRL_STAT, 8'h38);
        wr(`USC_ADDR_IRQ_CLK, 8'h80);
        wr(`USC_ADDR_TX_HOLD, 8'hAB);
        step(184);
        rchk(`USC_ADDR_RX_STAT, 8'h0A, 8'h0A);
        rchk(`USC_ADDR_RX_HOLD, 8'hFF, 8'hAB);
        step(8);
        rchk(`USC_ADDR_RX_STAT, 8'h02, 8'h00);
    endtask : t_loop
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence after a twelve cycle reset
    initial begin
        {rst_n, wr_s, rd_s, gp, addr, wdata} = '0;
        fails = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_formats();
        t_faults();
        t_address_wait_mode();
        t_tx();
        t_loop();
        tally_and_finish();
    end
    // Watchdog well beyond the dozen frames of the run
    initial begin
        #60000;
        fails++;
        tally_and_finish();
    end
endmodule : test_usart_status_control
